// >>> verilog/srfap_defines.svh
// Constants for the serial register and FIFO access port.
// Included by the device end and master end files by bare name; definitions only.
`ifndef SRFAP_DEFINES_SVH
`define SRFAP_DEFINES_SVH

// Address map seen over the serial link
`define SRFAP_ADDR_TXF   8'h80
`define SRFAP_ADDR_RXF   8'h81
`define SRFAP_ADDR_SKIP  8'h82
// Read of the write-only location returns this
`define SRFAP_RD_EMPTY   8'h00

// Header field positions
`define SRFAP_HDR_RW_BIT 7
`define SRFAP_LEN_W      7

// Link timing, ns, and system clock period
`define SRFAP_CLK_NS     10
`define SRFAP_TCP_NS     500
`define SRFAP_TSC_NS     250
`define SRFAP_TSS_NS     1000

// Least times round up to whole cycles
`define SRFAP_HALF_CYC   ((`SRFAP_TCP_NS / 2 + `SRFAP_CLK_NS - 1) / `SRFAP_CLK_NS)
`define SRFAP_TSC_CYC    ((`SRFAP_TSC_NS + `SRFAP_CLK_NS - 1) / `SRFAP_CLK_NS)
`define SRFAP_TSS_CYC    ((`SRFAP_TSS_NS + `SRFAP_CLK_NS - 1) / `SRFAP_CLK_NS)

`endif

// >>> verilog/srfap_pkg.sv
// Types shared by both ends of the serial access port.
// Assumes nothing; holds types only.
package srfap_pkg;
   typedef logic [7:0] srfap_byte_t;
   // Device transfer phase
   typedef enum logic [1:0] {
      PH_HDR,
      PH_ADDR,
      PH_DATA
   } srfap_phase_e;
   // Master sequencer
   typedef enum logic [2:0] {
      H_IDLE,
      H_SETUP,
      H_LOW,
      H_HIGH,
      H_FETCH,
      H_GAP
   } srfap_hstate_e;
endpackage

// >>> verilog/srfap_link_if.sv
// Serial link between master end and device end.
// The bench joins both modports; master-in wire resolved here.
`timescale 1ns/1ns
interface srfap_link_if;
   logic sck;
   logic ss_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic miso_line;

   // Undriven line reads low
   assign miso_line = miso_oe & miso;

   modport dev (
      input  sck,
      input  ss_n,
      input  mosi,
      output miso,
      output miso_oe
   );
   modport host (
      output sck,
      output ss_n,
      output mosi,
      input  miso_line
   );
endinterface

// >>> verilog/srfap_dev.sv
// Device end: serial slave giving access to registers and FIFOs.
// Link logic runs on the master's clock; user side on clk_i.
`timescale 1ns/1ns
`include "srfap_defines.svh"
module srfap_dev (
   // System clock and resets
   input  wire logic                 clk_i,
   input  wire logic                 resetn_i,
   input  wire logic                 chip_reset_n_i,
   // Link
   srfap_link_if.dev                 lnk,
   // Register bank and FIFO access
   output logic                      reg_wr_o,
   output logic                      reg_rd_o,
   output srfap_pkg::srfap_byte_t    reg_addr_o,
   output srfap_pkg::srfap_byte_t    reg_wdata_o,
   input  wire srfap_pkg::srfap_byte_t reg_rdata_i,
   // Configuration and parallel port pins
   input  wire logic                 spi_master_mode_i,
   input  wire logic                 par_rd_n_i,
   input  wire logic                 par_wr_n_i,
   input  wire logic                 par_ale_i,
   output logic                      par_off_o,
   output logic                      parallel_bus_oe_o
);
   localparam srfap_pkg::srfap_phase_e PH_HDR  = srfap_pkg::PH_HDR;
   localparam srfap_pkg::srfap_phase_e PH_ADDR = srfap_pkg::PH_ADDR;
   localparam srfap_pkg::srfap_phase_e PH_DATA = srfap_pkg::PH_DATA;
   // Burst address step; FIFO bursts stay put
   function automatic srfap_pkg::srfap_byte_t nxt_addr(input srfap_pkg::srfap_byte_t a);
      srfap_pkg::srfap_byte_t n;
      n = a + 8'h01;
      if (a == `SRFAP_ADDR_TXF || a == `SRFAP_ADDR_RXF) begin
         nxt_addr = a;
      end else if (n == `SRFAP_ADDR_TXF || n == `SRFAP_ADDR_RXF) begin
         nxt_addr = `SRFAP_ADDR_SKIP;
      end else begin
         nxt_addr = n;
      end
   endfunction

   // Link domain state
   logic [2:0]                 cnt_q, cnt_d;
   logic [6:0]                 sh_q, sh_d;
   srfap_pkg::srfap_phase_e    ph_q, ph_d;
   logic                       rw_q, rw_d;
   logic [`SRFAP_LEN_W-1:0]    len_q, len_d;
   srfap_pkg::srfap_byte_t     addr_q, addr_d;
   srfap_pkg::srfap_byte_t     req_addr_q, req_addr_d;
   srfap_pkg::srfap_byte_t     wbyte_q, wbyte_d;
   srfap_pkg::srfap_byte_t     rd_lat_q, rd_lat_d;
   logic                       wr_tgl_q, wr_tgl_d;
   logic                       rd_tgl_q, rd_tgl_d;
   logic                       mst1_q, mst2_q;
   logic                       miso_q;
   srfap_pkg::srfap_byte_t     byte_in;
   logic                       active;

   // System domain state
   srfap_pkg::srfap_byte_t     rd_hold_q, rd_hold_d;
   logic [2:0]                 wr_sy_q, rd_sy_q;
   logic                       wr_q, wr_d, rd_q, rd_d;
   srfap_pkg::srfap_byte_t     oaddr_q, oaddr_d, owdata_q, owdata_d;
   logic [1:0]                 cap_q, cap_d;
   logic                       txf_rd_q, txf_rd_d;
   logic [2:0]                 p1_q, p2_q;
   logic                       off_q, off_d, poe_q, poe_d;
   logic                       wr_ev, rd_ev;

   assign byte_in = {sh_q, lnk.mosi};
   assign active  = ~lnk.ss_n & ~mst2_q;

   always_comb begin
      cnt_d      = cnt_q;
      sh_d       = sh_q;
      ph_d       = ph_q;
      rw_d       = rw_q;
      len_d      = len_q;
      addr_d     = addr_q;
      req_addr_d = req_addr_q;
      wbyte_d    = wbyte_q;
      rd_lat_d   = rd_lat_q;
      wr_tgl_d   = wr_tgl_q;
      rd_tgl_d   = rd_tgl_q;
      if (active) begin
         cnt_d = cnt_q + 3'd1;
         sh_d  = {sh_q[5:0], lnk.mosi};
         // Read word fetched during the preceding gap
         if (cnt_q == 3'd0) begin
            rd_lat_d = rd_hold_q;
         end
         if (cnt_q == 3'd7) begin
            unique case (ph_q)
               PH_HDR: begin
                  rw_d  = byte_in[`SRFAP_HDR_RW_BIT];
                  len_d = byte_in[`SRFAP_LEN_W-1:0];
                  ph_d  = PH_ADDR;
               end
               PH_ADDR: begin
                  addr_d     = byte_in;
                  req_addr_d = byte_in;
                  // A zero count is dropped rather than wrapping
                  ph_d = (len_q == '0) ? PH_HDR : PH_DATA;
                  if (rw_q && len_q != '0) begin
                     rd_tgl_d = ~rd_tgl_q;
                  end
               end
               PH_DATA: begin
                  len_d  = len_q - 7'd1;
                  addr_d = nxt_addr(addr_q);
                  if (!rw_q) begin
                     req_addr_d = addr_q;
                     wbyte_d    = byte_in;
                     wr_tgl_d   = ~wr_tgl_q;
                  end else if (len_q != 7'd1) begin
                     req_addr_d = nxt_addr(addr_q);
                     rd_tgl_d   = ~rd_tgl_q;
                  end
                  if (len_q == 7'd1) begin
                     ph_d = PH_HDR;
                  end
               end
               default: ph_d = PH_HDR;
            endcase
         end
      end
   end

   // State held across select gaps, cleared only by chip reset
   always_ff @(posedge lnk.sck or negedge chip_reset_n_i) begin
      if (!chip_reset_n_i) begin
         cnt_q      <= 3'd0;
         sh_q       <= 7'h00;
         ph_q       <= PH_HDR;
         rw_q       <= 1'b0;
         len_q      <= '0;
         addr_q     <= 8'h00;
         req_addr_q <= 8'h00;
         wbyte_q    <= 8'h00;
         rd_lat_q   <= 8'h00;
         wr_tgl_q   <= 1'b0;
         rd_tgl_q   <= 1'b0;
         mst1_q     <= 1'b0;
         mst2_q     <= 1'b0;
      end else begin
         cnt_q      <= cnt_d;
         sh_q       <= sh_d;
         ph_q       <= ph_d;
         rw_q       <= rw_d;
         len_q      <= len_d;
         addr_q     <= addr_d;
         req_addr_q <= req_addr_d;
         wbyte_q    <= wbyte_d;
         rd_lat_q   <= rd_lat_d;
         wr_tgl_q   <= wr_tgl_d;
         rd_tgl_q   <= rd_tgl_d;
         mst1_q     <= spi_master_mode_i;
         mst2_q     <= mst1_q;
      end
   end

   // Outgoing bit moves on the falling edge
   always_ff @(negedge lnk.sck or negedge chip_reset_n_i) begin
      if (!chip_reset_n_i) begin
         miso_q <= 1'b0;
      end else begin
         miso_q <= rd_lat_q[~cnt_q];
      end
   end

   // First bit must stand before the first rising edge
   assign lnk.miso    = (cnt_q == 3'd0) ? rd_hold_q[7] : miso_q;
   assign lnk.miso_oe = active;

   // Toggle crossings; words are stable while the toggle settles
   assign wr_ev = wr_sy_q[2] ^ wr_sy_q[1];
   assign rd_ev = rd_sy_q[2] ^ rd_sy_q[1];

   always_comb begin
      wr_d     = 1'b0;
      rd_d     = 1'b0;
      oaddr_d  = oaddr_q;
      owdata_d = owdata_q;
      txf_rd_d = txf_rd_q;
      rd_hold_d = rd_hold_q;
      cap_d    = {cap_q[0], rd_ev};
      if (wr_ev) begin
         oaddr_d  = req_addr_q;
         owdata_d = wbyte_q;
         wr_d     = (req_addr_q != `SRFAP_ADDR_RXF);
      end else if (rd_ev) begin
         oaddr_d  = req_addr_q;
         rd_d     = (req_addr_q != `SRFAP_ADDR_TXF);
         txf_rd_d = (req_addr_q == `SRFAP_ADDR_TXF);
      end
      // Data returns one cycle after the read strobe
      if (cap_q[1]) begin
         rd_hold_d = txf_rd_q ? `SRFAP_RD_EMPTY : reg_rdata_i;
      end
      off_d = p2_q[0] & p2_q[1] & p2_q[2];
      poe_d = ~p2_q[0] & ~off_d;
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wr_sy_q   <= 3'b000;
         rd_sy_q   <= 3'b000;
         wr_q      <= 1'b0;
         rd_q      <= 1'b0;
         oaddr_q   <= 8'h00;
         owdata_q  <= 8'h00;
         txf_rd_q  <= 1'b0;
         rd_hold_q <= 8'h00;
         cap_q     <= 2'b00;
         p1_q      <= 3'b111;
         p2_q      <= 3'b111;
         off_q     <= 1'b1;
         poe_q     <= 1'b0;
      end else begin
         wr_sy_q   <= {wr_sy_q[1:0], wr_tgl_q};
         rd_sy_q   <= {rd_sy_q[1:0], rd_tgl_q};
         wr_q      <= wr_d;
         rd_q      <= rd_d;
         oaddr_q   <= oaddr_d;
         owdata_q  <= owdata_d;
         txf_rd_q  <= txf_rd_d;
         rd_hold_q <= rd_hold_d;
         cap_q     <= cap_d;
         p1_q      <= {par_ale_i, par_wr_n_i, par_rd_n_i};
         p2_q      <= p1_q;
         off_q     <= off_d;
         poe_q     <= poe_d;
      end
   end

   assign reg_wr_o          = wr_q;
   assign reg_rd_o          = rd_q;
   assign reg_addr_o        = oaddr_q;
   assign reg_wdata_o       = owdata_q;
   assign par_off_o         = off_q;
   assign parallel_bus_oe_o = poe_q;
endmodule

// >>> verilog/srfap_host.sv
// Master end: runs transfers to the device over the serial link.
// Makes the serial clock by dividing clk_i; one command at a time.
`timescale 1ns/1ns
`include "srfap_defines.svh"
module srfap_host #(
   parameter int HALF_CYC = `SRFAP_HALF_CYC,
   parameter int TSC_CYC  = `SRFAP_TSC_CYC,
   parameter int TSS_CYC  = `SRFAP_TSS_CYC
) (
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   resetn_i,
   // Link
   srfap_link_if.host                  lnk,
   // Command
   input  wire logic                   cmd_valid_i,
   output logic                        cmd_ready_o,
   input  wire logic                   cmd_read_i,
   input  wire logic [`SRFAP_LEN_W-1:0] cmd_len_i,
   input  wire srfap_pkg::srfap_byte_t cmd_addr_i,
   // Write data
   input  wire logic                   wr_valid_i,
   input  wire srfap_pkg::srfap_byte_t wr_data_i,
   output logic                        wr_ready_o,
   // Read data
   output srfap_pkg::srfap_byte_t      rd_data_o,
   output logic                        rd_valid_o
);
   // Master-in sync needs two cycles after select falls and after each fall
   if (HALF_CYC < 4 || HALF_CYC > 255 || TSC_CYC < 3 || TSC_CYC > 255
       || TSS_CYC < 8 || TSS_CYC > 255) begin : g_chk
      $error("srfap_host: timing parameter out of range");
   end

   localparam srfap_pkg::srfap_hstate_e H_IDLE  = srfap_pkg::H_IDLE;
   localparam srfap_pkg::srfap_hstate_e H_SETUP = srfap_pkg::H_SETUP;
   localparam srfap_pkg::srfap_hstate_e H_LOW   = srfap_pkg::H_LOW;
   localparam srfap_pkg::srfap_hstate_e H_HIGH  = srfap_pkg::H_HIGH;
   localparam srfap_pkg::srfap_hstate_e H_FETCH = srfap_pkg::H_FETCH;
   localparam srfap_pkg::srfap_hstate_e H_GAP   = srfap_pkg::H_GAP;

   srfap_pkg::srfap_hstate_e st_q, st_d;
   logic [7:0]             tmr_q, tmr_d, byte_q, byte_d, nbyte;
   logic [2:0]             bit_q, bit_d;
   srfap_pkg::srfap_byte_t tx_q, tx_d, addr_q, addr_d, rdat_q, rdat_d;
   logic [6:0]             rx_q, rx_d;
   logic [`SRFAP_LEN_W-1:0] len_q, len_d;
   logic                   rw_q, rw_d, sck_q, sck_d, ss_q, ss_d, mo_q, mo_d;
   logic                   rv_q, rv_d, wrdy_q, wrdy_d, crdy_q, crdy_d;
   logic                   m1_q, m2_q;

   assign nbyte = byte_q + 8'd1;

   always_comb begin
      st_d = st_q; tmr_d = tmr_q; byte_d = byte_q; bit_d = bit_q;
      tx_d = tx_q; addr_d = addr_q; rdat_d = rdat_q; rx_d = rx_q;
      len_d = len_q; rw_d = rw_q; sck_d = sck_q; ss_d = ss_q; mo_d = mo_q;
      rv_d = 1'b0;
      if (tmr_q != 8'd0) begin
         tmr_d = tmr_q - 8'd1;
      end
      unique case (st_q)
         H_IDLE: if (cmd_valid_i && crdy_q) begin
            rw_d   = cmd_read_i;
            len_d  = cmd_len_i;
            addr_d = cmd_addr_i;
            tx_d   = {cmd_read_i, cmd_len_i};
            mo_d   = cmd_read_i;
            byte_d = 8'd0;
            bit_d  = 3'd0;
            ss_d   = 1'b0;
            tmr_d  = 8'(TSC_CYC - 1);
            st_d   = H_SETUP;
         end
         H_SETUP, H_LOW: if (tmr_q == 8'd0) begin
            sck_d = 1'b1;
            rx_d  = {rx_q[5:0], m2_q};
            if (bit_q == 3'd7) begin
               rdat_d = {rx_q, m2_q};
               rv_d   = rw_q && byte_q >= 8'd2;
            end
            tmr_d = 8'(HALF_CYC - 1);
            st_d  = H_HIGH;
         end
         H_HIGH: if (tmr_q == 8'd0) begin
            sck_d = 1'b0;
            bit_d = bit_q + 3'd1;
            tmr_d = 8'(HALF_CYC - 1);
            st_d  = H_LOW;
            if (bit_q != 3'd7) begin
               tx_d = {tx_q[6:0], 1'b0};
               mo_d = tx_q[6];
            end else begin
               byte_d = nbyte;
               if (nbyte == 8'({1'b0, len_q}) + 8'd2) begin
                  ss_d  = 1'b1;
                  tmr_d = 8'(TSS_CYC - 1);
                  st_d  = H_GAP;
               end else if (nbyte == 8'd1) begin
                  tx_d = addr_q;
                  mo_d = addr_q[7];
               end else if (rw_q) begin
                  // Slave refills its output during the gap
                  tx_d  = 8'h00;
                  mo_d  = 1'b0;
                  ss_d  = 1'b1;
                  tmr_d = 8'(TSS_CYC - 1);
                  st_d  = H_GAP;
               end else begin
                  st_d = H_FETCH;
               end
            end
         end
         H_FETCH: if (wr_valid_i && wrdy_q) begin
            tx_d  = wr_data_i;
            mo_d  = wr_data_i[7];
            tmr_d = 8'(HALF_CYC - 1);
            st_d  = H_LOW;
         end
         H_GAP: if (tmr_q == 8'd0) begin
            if (byte_q == 8'({1'b0, len_q}) + 8'd2) begin
               st_d = H_IDLE;
            end else begin
               ss_d  = 1'b0;
               tmr_d = 8'(TSC_CYC - 1);
               st_d  = H_SETUP;
            end
         end
         default: st_d = H_IDLE;
      endcase
      crdy_d = (st_d == H_IDLE);
      wrdy_d = (st_d == H_FETCH) && !(st_q == H_FETCH && wr_valid_i && wrdy_q);
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st_q <= H_IDLE; tmr_q <= 8'd0; byte_q <= 8'd0; bit_q <= 3'd0;
         tx_q <= 8'h00; addr_q <= 8'h00; rdat_q <= 8'h00; rx_q <= 7'h00;
         len_q <= '0; rw_q <= 1'b0; sck_q <= 1'b0; ss_q <= 1'b1;
         mo_q <= 1'b0; rv_q <= 1'b0; wrdy_q <= 1'b0; crdy_q <= 1'b0;
         m1_q <= 1'b0; m2_q <= 1'b0;
      end else begin
         st_q <= st_d; tmr_q <= tmr_d; byte_q <= byte_d; bit_q <= bit_d;
         tx_q <= tx_d; addr_q <= addr_d; rdat_q <= rdat_d; rx_q <= rx_d;
         len_q <= len_d; rw_q <= rw_d; sck_q <= sck_d; ss_q <= ss_d;
         mo_q <= mo_d; rv_q <= rv_d; wrdy_q <= wrdy_d; crdy_q <= crdy_d;
         m1_q <= lnk.miso_line;
         m2_q <= m1_q;
      end
   end

   assign lnk.sck     = sck_q;
   assign lnk.ss_n    = ss_q;
   assign lnk.mosi    = mo_q;
   assign cmd_ready_o = crdy_q;
   assign wr_ready_o  = wrdy_q;
   assign rd_data_o   = rdat_q;
   assign rd_valid_o  = rv_q;
endmodule

// >>> tb/srfap_link_monitor.sv
// Checker for the serial link between the two ends.
// Sees only link signals plus the system clock and its reset.
`timescale 1ns/1ns
module srfap_link_monitor #(
   parameter int HALF_CYC = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Link
   input wire logic sck,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   chk_miso_release: assert property (ss_n |-> !miso_oe)
      else $error("miso driven while deselected");
   chk_sck_idle: assert property (ss_n |-> !sck)
      else $error("serial clock not idle outside frame");
   chk_sck_in_frame: assert property ($rose(sck) |-> !ss_n && $past(!ss_n))
      else $error("clock edge without select");
   chk_ss_setup: assert property ($fell(ss_n) |-> !sck ##1 !sck)
      else $error("select to clock too short");
   chk_mosi_stable: assert property (sck |-> $stable(mosi))
      else $error("mosi moved while clock high");
   chk_half_period: assert property ($rose(sck) |-> ##HALF_CYC $fell(sck))
      else $error("clock high time wrong");
   chk_gap_length: assert property ($rose(ss_n) |-> ss_n[*8])
      else $error("select gap too short");
   chk_miso_hold: assert property (miso_oe && $past(miso_oe) && sck && $past(sck)
      |-> $stable(miso))
      else $error("miso moved while clock high");
endmodule

// >>> tb/serial_register_fifo_access_port_test.sv
// Bench joining master end and device end over the link.
// Models the register bank on the device user side.
`timescale 1ns/1ns
module serial_register_fifo_access_port_test;
   localparam int HALF = 4;
   logic       clk_i = 1'b0, resetn_i = 1'b0, chip_reset_n_i = 1'b0;
   logic       reg_wr_o, reg_rd_o, par_off_o, parallel_bus_oe_o;
   logic [7:0] reg_addr_o, reg_wdata_o, reg_rdata_i, rd_data_o, wr_data_i, cmd_addr_i;
   logic       spi_master_mode_i, par_rd_n_i, par_wr_n_i, par_ale_i;
   logic       cmd_valid_i, cmd_ready_o, cmd_read_i, wr_valid_i, wr_ready_o, rd_valid_o;
   logic [6:0] cmd_len_i;
   logic [7:0] mem [256], shad [256];
   logic [15:0] exp_wr [$], exp_hw [$], sh;
   logic [7:0] exp_ra [$], exp_rd [$];
   logic       sck_prev = 1'b0;
   int         failures = 0, n_compared = 0, seed = 13, bc = 16, i;

   srfap_link_if lnk ();
   srfap_dev i_srfap_dev (.clk_i(clk_i), .resetn_i(resetn_i),
      .chip_reset_n_i(chip_reset_n_i), .lnk(lnk.dev), .reg_wr_o(reg_wr_o),
      .reg_rd_o(reg_rd_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
      .reg_rdata_i(reg_rdata_i), .spi_master_mode_i(spi_master_mode_i),
      .par_rd_n_i(par_rd_n_i), .par_wr_n_i(par_wr_n_i), .par_ale_i(par_ale_i),
      .par_off_o(par_off_o), .parallel_bus_oe_o(parallel_bus_oe_o));
   // Short counts keep the run brief; gap stays above the device minimum
   srfap_host #(.HALF_CYC(HALF), .TSC_CYC(4), .TSS_CYC(10)) i_srfap_host (
      .clk_i(clk_i), .resetn_i(resetn_i), .lnk(lnk.host), .cmd_valid_i(cmd_valid_i),
      .cmd_ready_o(cmd_ready_o), .cmd_read_i(cmd_read_i), .cmd_len_i(cmd_len_i),
      .cmd_addr_i(cmd_addr_i), .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i),
      .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
   srfap_link_monitor #(.HALF_CYC(HALF)) i_srfap_link_monitor (.clk_i(clk_i),
      .resetn_i(resetn_i), .sck(lnk.sck), .ss_n(lnk.ss_n), .mosi(lnk.mosi),
      .miso(lnk.miso), .miso_oe(lnk.miso_oe));

   always #5 clk_i = ~clk_i;

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_word({8'h00, got}, {8'h00, exp});
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Sel 1 waits for command ready, 0 for write-data ready
   task automatic wait_hi(input bit sel);
      int k;
      for (k = 0; k < 5000; k++) begin
         @(posedge clk_i);
         if ((sel ? cmd_ready_o : wr_ready_o) === 1'b1)
            break;
      end
      if (k == 5000) begin
         failures++;
         conclude();
      end
      @(negedge clk_i);
   endtask

   function automatic logic [7:0] nxt(input logic [7:0] p);
      logic [7:0] q;
      q = p + 8'h01;
      if (p == 8'h80 || p == 8'h81)
         return p;
      return (q == 8'h80 || q == 8'h81) ? 8'h82 : q;
   endfunction

   task automatic xfer(input logic rd, input int n, input logic [7:0] a);
      logic [7:0] p;
      logic [7:0] d;
      int k;
      p = a;
      exp_hw.push_back({rd, 7'(n), a});
      @(negedge clk_i);
      cmd_valid_i = 1'b1;
      cmd_read_i = rd;
      cmd_len_i = 7'(n);
      cmd_addr_i = a;
      wait_hi(1'b1);
      cmd_valid_i = 1'b0;
      bc = 0;
      for (k = 0; k < n; k++) begin
         d = 8'($random(seed));
         if (rd) begin
            exp_rd.push_back((spi_master_mode_i || p == 8'h80) ? 8'h00 : shad[p]);
            if (!spi_master_mode_i && p != 8'h80)
               exp_ra.push_back(p);
         end else begin
            if (!spi_master_mode_i && p != 8'h81) begin
               exp_wr.push_back({p, d});
               shad[p] = d;
            end
            wr_valid_i = 1'b1;
            wr_data_i = d;
            wait_hi(1'b0);
         end
         p = nxt(p);
      end
      // Valid stays up between bytes; ready alone paces them
      wr_valid_i = 1'b0;
      wait_hi(1'b1);
   endtask

   // Register bank model answers on the falling edge inside the read strobe cycle
   always @(negedge clk_i)
      if (reg_rd_o === 1'b1)
         reg_rdata_i <= mem[reg_addr_o];

   always @(posedge clk_i) begin
      if (resetn_i === 1'b1) begin
         if (reg_wr_o === 1'b1) begin
            mem[reg_addr_o] = reg_wdata_o;
            cmp_word({reg_addr_o, reg_wdata_o}, exp_wr.size() ? exp_wr.pop_front() : 'x);
         end
         if (reg_rd_o === 1'b1)
            cmp_byte(reg_addr_o, exp_ra.size() ? exp_ra.pop_front() : 'x);
         if (rd_valid_o === 1'b1)
            cmp_byte(rd_data_o, exp_rd.size() ? exp_rd.pop_front() : 'x);
         if (lnk.sck === 1'b1 && sck_prev === 1'b0 && lnk.ss_n === 1'b0 && bc < 16) begin
            sh = {sh[14:0], lnk.mosi};
            bc++;
            if (bc == 16)
               cmp_word(sh, exp_hw.size() ? exp_hw.pop_front() : 'x);
         end
      end
      sck_prev = lnk.sck;
   end

   initial begin
      {cmd_valid_i, cmd_read_i, wr_valid_i, spi_master_mode_i} = 4'h0;
      {cmd_len_i, cmd_addr_i, wr_data_i, reg_rdata_i} = 31'h0;
      {par_rd_n_i, par_wr_n_i, par_ale_i} = 3'h7;
      for (i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'hA5;
         shad[i] = mem[i];
      end
      repeat (4) @(negedge clk_i);
      resetn_i = 1'b1;
      chip_reset_n_i = 1'b1;
      for (i = 0; i < 8; i++) begin
         {par_rd_n_i, par_wr_n_i, par_ale_i} = 3'(i);
         repeat (6) @(negedge clk_i);
         cmp_byte({7'h00, par_off_o}, {7'h00, 1'(i == 7)});
         cmp_byte({7'h00, parallel_bus_oe_o}, {7'h00, 1'(i < 4)});
      end
      $display("test parallel port done");
      xfer(1'b0, 4, 8'h7E);
      xfer(1'b1, 4, 8'h7E);
      xfer(1'b0, 3, 8'hFE);
      xfer(1'b1, 3, 8'hFE);
      $display("test burst skip and wrap done");
      xfer(1'b0, 3, 8'h80);
      xfer(1'b0, 2, 8'h81);
      xfer(1'b1, 2, 8'h80);
      xfer(1'b1, 3, 8'h81);
      $display("test fifo locations done");
      spi_master_mode_i = 1'b1;
      xfer(1'b0, 2, 8'h10);
      xfer(1'b1, 1, 8'h10);
      spi_master_mode_i = 1'b0;
      chip_reset_n_i = 1'b0;
      @(negedge clk_i);
      chip_reset_n_i = 1'b1;
      xfer(1'b1, 2, 8'h10);
      $display("test master mode and chip reset done");
      // Lengths held within one through six
      for (i = 0; i < 8; i++)
         xfer(1'($random(seed)), 1 + {$random(seed)} % 6, 8'($random(seed)));
      xfer(1'b0, 127, 8'h00);
      xfer(1'b1, 3, 8'h7D);
      $display("test random and longest burst done");
      repeat (20) @(negedge clk_i);
      cmp_byte(8'(exp_wr.size() + exp_rd.size() + exp_ra.size() + exp_hw.size()), 8'h00);
      conclude();
   end
endmodule
